// >>> rtl/nicfg_top.sv
`timescale 1ns/1ps
// Operation
// - host reads and writes boot rom bytewise via address and data ports
// - configuration register is loaded from eeprom shortly after reset release
// - first eeprom word fills low 16 bits, second fills high 16 bits
// - register holds 00000010h until the first eeprom word is taken
// - bits 7:6 give rom size: 0 is 64 KB, 1 is 128 KB
// - bit 8 set skips the start delimiter j/k check
// - bit 8 clear checks j/k and counts bad delimiters when statistics on
// - delimiter check bit matters only in 100BASE-TX modes
// - bit 14 allows transmit frames longer than the transmit fifo; resets clear
// - bit 15 allows receive frames longer than the receive fifo; resets clear
// - both fifos hold 2 KB, so oversize bits may stay clear
// - bits 23:20 select transceiver; software writes supported values then resets
module nicfg_top #(
    parameter int ROM_AW     = 17,
    parameter int FIFO_BYTES = nicfg_pkg::FIFO_BYTES
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    // host i/o register port
    input  wire logic [2:0]  io_window,
    input  wire logic [3:0]  io_offset,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [31:0] io_wdata,
    output logic      [31:0] io_rdata,
    output logic             io_rvalid,
    // eeprom word source
    output logic             ee_req,
    output logic             ee_word_sel,
    input  wire logic        ee_ack,
    input  wire logic [15:0] ee_data,
    // receive path delimiter status
    input  wire logic        rx_delim_valid,
    input  wire logic        rx_delim_jk_ok,
    input  wire logic        stats_enable,
    // configuration outputs
    output logic             load_done,
    output logic [1:0]       boot_rom_size,
    output logic             delimiter_check_off,
    output logic             oversize_transmit_allow,
    output logic             oversize_receive_allow,
    output logic [3:0]       transceiver_choice,
    output logic [15:0]      bad_delimiter_counter,
    output logic             rom_too_big
);
    typedef struct packed {
        nicfg_pkg::nicfg_load_t st;
        logic [3:0]             dly;
        logic [31:0]            cfg;
        logic [ROM_AW-1:0]      rom_addr;
        logic [15:0]            bad_cnt;
        logic [31:0]            rdata;
        logic                   rvalid;
        logic                   done;
        logic                   too_big;
        logic                   rd_rom_p;
        logic                   ee_req;
        logic                   ee_sel;
    } nicfg_state_t;

    nicfg_state_t q, d;
    logic [7:0]   rom_rdata;
    logic         sel_win;
    logic         rom_we;

    function automatic logic hit(input logic [2:0] w, input logic [3:0] o, input logic [3:0] ofs);
        hit = (w == nicfg_pkg::WIN_CFG) && (o == ofs);
    endfunction

    assign sel_win = (io_window == nicfg_pkg::WIN_CFG);
    assign rom_we  = io_wr && hit(io_window, io_offset, nicfg_pkg::OFS_ROM_DATA);

    nicfg_rom_mem #(.AW(ROM_AW)) u_rom (
        .clk   (clk),
        .we    (rom_we),
        .addr  (q.rom_addr),
        .wdata (io_wdata[7:0]),
        .rdata (rom_rdata)
    );

    always_comb begin
        d          = q;
        d.rvalid   = 1'b0;
        d.rd_rom_p = 1'b0;
        case (q.st)
            nicfg_pkg::NICFG_IDLE: begin
                d.st  = nicfg_pkg::NICFG_WAIT;
                d.dly = nicfg_pkg::LOAD_DELAY;
            end
            nicfg_pkg::NICFG_WAIT: begin
                d.dly = q.dly - 4'h1;
                if (q.dly == 4'h0) begin
                    d.st     = nicfg_pkg::NICFG_REQ0;
                    d.ee_req = 1'b1;
                    d.ee_sel = 1'b0;
                end
            end
            nicfg_pkg::NICFG_REQ0: begin
                if (ee_ack) begin
                    d.cfg[15:0] = ee_data & nicfg_pkg::CFG_DEFINED[15:0];
                    d.ee_sel    = 1'b1;
                    d.st        = nicfg_pkg::NICFG_REQ1;
                end
            end
            nicfg_pkg::NICFG_REQ1: begin
                if (ee_ack) begin
                    d.cfg[31:16] = ee_data & nicfg_pkg::CFG_DEFINED[31:16];
                    d.ee_req     = 1'b0;
                    d.st         = nicfg_pkg::NICFG_DONE;
                end
            end
            nicfg_pkg::NICFG_DONE: begin
            end
            default: begin
                d.st = nicfg_pkg::NICFG_IDLE;
            end
        endcase
        // host writes take effect only once the load is done; every defined field stays writable, keeping it is up to software
        if (io_wr && hit(io_window, io_offset, nicfg_pkg::OFS_CFG) && q.st == nicfg_pkg::NICFG_DONE) begin
            d.cfg = io_wdata & nicfg_pkg::CFG_DEFINED;
        end
        if (io_wr && hit(io_window, io_offset, nicfg_pkg::OFS_ROM_ADDR)) begin
            d.rom_addr = io_wdata[ROM_AW-1:0];
        end
        if (io_rd && sel_win) begin
            if (io_offset == nicfg_pkg::OFS_ROM_DATA) begin
                // rom data is one cycle late from the memory, so answer a cycle later
                d.rd_rom_p = 1'b1;
            end else begin
                d.rvalid = 1'b1;
                if (io_offset == nicfg_pkg::OFS_CFG) begin
                    d.rdata = q.cfg & nicfg_pkg::CFG_DEFINED;
                end else if (io_offset == nicfg_pkg::OFS_ROM_ADDR) begin
                    d.rdata = 32'(q.rom_addr);
                end else begin
                    d.rdata = 32'h0000_0000;
                end
            end
        end
        if (q.rd_rom_p) begin
            d.rvalid = 1'b1;
            d.rdata  = {24'h00_0000, rom_rdata};
        end
        // bad delimiter counting only in a 100BASE-TX mode with check enabled
        if (rx_delim_valid && !rx_delim_jk_ok && stats_enable && !q.cfg[nicfg_pkg::POS_DELIM_OFF]
            && (q.cfg[nicfg_pkg::POS_XCVR+:4] == nicfg_pkg::XCVR_100TX
                || q.cfg[nicfg_pkg::POS_XCVR+:4] == nicfg_pkg::XCVR_AUTONEG)) begin
            d.bad_cnt = q.bad_cnt + 16'h0001;
        end
        // status kept in flops so the outputs never glitch off decode logic
        d.done    = (d.st == nicfg_pkg::NICFG_DONE);
        // flags only the reserved rom sizes; 64 KB and 128 KB both leave rom_too_big clear
        d.too_big = (d.cfg[nicfg_pkg::POS_ROM_SIZE+:2] != nicfg_pkg::ROM_64K)
                    && (d.cfg[nicfg_pkg::POS_ROM_SIZE+:2] != nicfg_pkg::ROM_128K);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            q          <= '0;
            q.st       <= nicfg_pkg::NICFG_IDLE;
            q.cfg      <= nicfg_pkg::CFG_RESET;
        end else begin
            q <= d;
        end
    end

    assign io_rdata                = q.rdata;
    assign io_rvalid               = q.rvalid;
    assign ee_req                  = q.ee_req;
    assign ee_word_sel             = q.ee_sel;
    assign load_done               = q.done;
    assign boot_rom_size           = q.cfg[nicfg_pkg::POS_ROM_SIZE+:2];
    assign delimiter_check_off     = q.cfg[nicfg_pkg::POS_DELIM_OFF];
    assign oversize_transmit_allow = q.cfg[nicfg_pkg::POS_TX_LARGE];
    assign oversize_receive_allow  = q.cfg[nicfg_pkg::POS_RX_LARGE];
    assign transceiver_choice      = q.cfg[nicfg_pkg::POS_XCVR+:4];
    assign bad_delimiter_counter   = q.bad_cnt;
    assign rom_too_big             = q.too_big;

    // the two eeprom word hand-overs that the load properties are built from
    sequence s_word0_taken;
        q.st == nicfg_pkg::NICFG_REQ0 && ee_ack;
    endsequence
    sequence s_word1_taken;
        q.st == nicfg_pkg::NICFG_REQ1 && ee_ack;
    endsequence

    a_reset_value: assert property (@(posedge clk) !nrst |=> io_rvalid == 1'b0 && load_done == 1'b0)
        else $error("state after reset wrong");
    a_hold_reset: assert property (@(posedge clk) disable iff (!nrst)
        (q.st != nicfg_pkg::NICFG_DONE && $past(q.st) == nicfg_pkg::NICFG_WAIT) |-> q.cfg == nicfg_pkg::CFG_RESET)
        else $error("config changed before load");
    a_undef_zero: assert property (@(posedge clk) disable iff (!nrst)
        io_rvalid && $past(io_rd) && $past(io_offset) == nicfg_pkg::OFS_CFG && $past(sel_win)
        |-> (io_rdata & ~nicfg_pkg::CFG_DEFINED) == 32'h0000_0000)
        else $error("undefined bits not zero");
    a_low_word: assert property (@(posedge clk) disable iff (!nrst)
        s_word0_taken |=> q.cfg[15:0] == ($past(ee_data) & 16'hc1d0))
        else $error("low word not loaded");
    a_load_order: assert property (@(posedge clk) disable iff (!nrst)
        s_word0_taken |=> ee_req && ee_word_sel && !load_done)
        else $error("second word not requested");
    a_high_word: assert property (@(posedge clk) disable iff (!nrst)
        s_word1_taken |=> !ee_req && load_done && transceiver_choice == $past(ee_data[7:4]))
        else $error("high word not loaded");
    a_load_start: assert property (@(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> ##[1:8] ee_req)
        else $error("eeprom load never started");
    a_delim_skip: assert property (@(posedge clk) disable iff (!nrst)
        delimiter_check_off |=> bad_delimiter_counter == $past(bad_delimiter_counter))
        else $error("count while check off");
    a_delim_count: assert property (@(posedge clk) disable iff (!nrst)
        rx_delim_valid && !rx_delim_jk_ok && stats_enable && !delimiter_check_off
        && transceiver_choice == nicfg_pkg::XCVR_100TX
        |=> bad_delimiter_counter == $past(bad_delimiter_counter) + 16'h0001)
        else $error("bad delimiter not counted");
    a_mode_gate: assert property (@(posedge clk) disable iff (!nrst)
        transceiver_choice != nicfg_pkg::XCVR_100TX && transceiver_choice != nicfg_pkg::XCVR_AUTONEG
        |=> $stable(bad_delimiter_counter))
        else $error("count outside 100tx mode");
    a_rom_read: assert property (@(posedge clk) disable iff (!nrst)
        io_rd && hit(io_window, io_offset, nicfg_pkg::OFS_ROM_DATA) |-> ##2 io_rvalid)
        else $error("rom read not answered");
    a_large_bits: assert property (@(posedge clk) disable iff (!nrst)
        io_wr && hit(io_window, io_offset, nicfg_pkg::OFS_CFG) && load_done
        |=> oversize_transmit_allow == $past(io_wdata[14]) && oversize_receive_allow == $past(io_wdata[15]))
        else $error("oversize bits not written");
endmodule

// >>> rtl/nicfg_pkg.sv
package nicfg_pkg;
    // register map, reached as documented at window 3
    localparam logic [2:0]  WIN_CFG         = 3'h3;
    localparam logic [3:0]  OFS_CFG         = 4'h0;
    localparam logic [3:0]  OFS_ROM_ADDR    = 4'h8;
    localparam logic [3:0]  OFS_ROM_DATA    = 4'hc;
    localparam logic [31:0] CFG_RESET       = 32'h0000_0010;
    // bits that hold a defined field; everything else reads zero
    localparam logic [31:0] CFG_DEFINED     = 32'h03f0_c1d0;
    localparam int          POS_ROM_SIZE    = 6;
    localparam int          POS_DELIM_OFF   = 8;
    localparam int          POS_TX_LARGE    = 14;
    localparam int          POS_RX_LARGE    = 15;
    localparam int          POS_XCVR        = 20;
    localparam logic [1:0]  ROM_64K         = 2'h0;
    localparam logic [1:0]  ROM_128K        = 2'h1;
    localparam logic [3:0]  XCVR_100TX      = 4'h4;
    localparam logic [3:0]  XCVR_AUTONEG    = 4'h8;
    localparam int          FIFO_BYTES      = 2048;
    localparam logic [3:0]  LOAD_DELAY      = 4'h4;

    typedef enum logic [2:0] {
        NICFG_IDLE  = 3'b000,
        NICFG_WAIT  = 3'b001,
        NICFG_REQ0  = 3'b010,
        NICFG_REQ1  = 3'b011,
        NICFG_DONE  = 3'b100
    } nicfg_load_t;
endpackage

// >>> rtl/nicfg_rom_mem.sv
`timescale 1ns/1ps
// byte-wide boot rom store; registered read data
module nicfg_rom_mem #(
    parameter int AW = 17
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata
);
    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [2:0]  io_window = 3'h3;
    logic [3:0]  io_offset = 4'h0;
    logic        io_wr = 1'b0;
    logic        io_rd = 1'b0;
    logic [31:0] io_wdata = 32'h0;
    logic [31:0] io_rdata;
    logic        io_rvalid;
    logic        ee_req;
    logic        ee_word_sel;
    logic        ee_ack = 1'b0;
    logic [15:0] ee_data = 16'h0;
    logic        rx_delim_valid = 1'b0;
    logic        rx_delim_jk_ok = 1'b1;
    logic        stats_enable = 1'b1;
    logic        load_done;
    logic [1:0]  boot_rom_size;
    logic        delimiter_check_off;
    logic        oversize_transmit_allow;
    logic        oversize_receive_allow;
    logic [3:0]  transceiver_choice;
    logic [15:0] bad_delimiter_counter;
    logic        rom_too_big;
    logic [31:0] lfsr = 32'h477ffd91;
    logic [31:0] rv;
    logic [31:0] cfg_exp;
    logic [15:0] cnt_exp = 16'h0;
    logic [16:0] rom_a [8];
    logic [7:0]  rom_d [8];
    int          err_count = 0;
    int          n_tests = 0;

    always #10 clk = ~clk;

    nicfg_top dut (.clk(clk), .nrst(nrst), .io_window(io_window), .io_offset(io_offset), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .ee_req(ee_req),
        .ee_word_sel(ee_word_sel), .ee_ack(ee_ack), .ee_data(ee_data), .rx_delim_valid(rx_delim_valid),
        .rx_delim_jk_ok(rx_delim_jk_ok), .stats_enable(stats_enable), .load_done(load_done),
        .boot_rom_size(boot_rom_size), .delimiter_check_off(delimiter_check_off),
        .oversize_transmit_allow(oversize_transmit_allow), .oversize_receive_allow(oversize_receive_allow),
        .transceiver_choice(transceiver_choice), .bad_delimiter_counter(bad_delimiter_counter),
        .rom_too_big(rom_too_big));

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction

    // a bad delimiter counts only with stats on, check on and a 100BASE-TX mode (4 or 8)
    function automatic logic counts(input logic jk, input logic st, input logic [31:0] c);
        return !jk && st && !c[8] && (c[23:20] == 4'h4 || c[23:20] == 4'h8);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic io_write(input logic [3:0] ofs, input logic [31:0] d);
        @(negedge clk);
        io_offset = ofs;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
    endtask

    // waits out the two-cycle answer of the rom data port too
    task automatic io_read(input logic [3:0] ofs, output logic [31:0] d);
        @(negedge clk);
        io_offset = ofs;
        io_rd = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        for (int i = 0; i < 3 && io_rvalid !== 1'b1; i++) @(negedge clk);
        chk({31'h0, io_rvalid}, 32'h1);
        d = io_rdata;
    endtask

    task automatic check_fields;
        chk({22'h0, rom_too_big, boot_rom_size, delimiter_check_off, oversize_transmit_allow, oversize_receive_allow,
             transceiver_choice}, {22'h0, cfg_exp[7], cfg_exp[7:6], cfg_exp[8], cfg_exp[14], cfg_exp[15],
             cfg_exp[23:20]});
    endtask

    task automatic set_cfg(input logic [31:0] v);
        io_write(nicfg_pkg::OFS_CFG, v);
        cfg_exp = v & nicfg_pkg::CFG_DEFINED;
        io_read(nicfg_pkg::OFS_CFG, rv);
        chk(rv, cfg_exp);
        check_fields();
    endtask

    task automatic ee_word(input logic sel, input logic [15:0] w);
        @(negedge clk);
        for (int i = 0; i < 50 && !(ee_req === 1'b1 && ee_word_sel === sel); i++) @(negedge clk);
        chk({30'h0, ee_req, ee_word_sel}, {30'h0, 1'b1, sel});
        ee_data = w;
        ee_ack = 1'b1;
        @(negedge clk);
        ee_ack = 1'b0;
        ee_data = ~w;
    endtask

    task automatic delim(input logic jk, input logic st);
        @(negedge clk);
        rx_delim_valid = 1'b1;
        rx_delim_jk_ok = jk;
        stats_enable = st;
        @(negedge clk);
        rx_delim_valid = 1'b0;
        rx_delim_jk_ok = ~jk;
        if (counts(jk, st, cfg_exp)) cnt_exp++;
        @(negedge clk);
        chk({16'h0, bad_delimiter_counter}, {16'h0, cnt_exp});
    endtask

    initial begin
        #(20 * 20000);
        err_count++;
        end_sim();
    end

    initial begin
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        io_read(nicfg_pkg::OFS_CFG, rv);
        chk(rv, 32'h0000_0010);
        chk({30'h0, oversize_transmit_allow, oversize_receive_allow}, 32'h0);
        io_write(nicfg_pkg::OFS_CFG, 32'hffff_ffff);
        io_read(nicfg_pkg::OFS_CFG, rv);
        chk({rv[31:1], load_done}, 32'h0000_0010);
        @(negedge clk);
        io_window = 3'h2;
        io_rd = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        chk({31'h0, io_rvalid}, 32'h0);
        io_window = 3'h3;
        $display("reset test done");
        lfsr = next_rand(lfsr);
        ee_word(1'b0, lfsr[15:0]);
        ee_word(1'b1, lfsr[31:16]);
        repeat (2) @(negedge clk);
        chk({30'h0, ee_req, load_done}, 32'h1);
        cfg_exp = lfsr & nicfg_pkg::CFG_DEFINED;
        io_read(nicfg_pkg::OFS_CFG, rv);
        chk(rv, cfg_exp);
        check_fields();
        $display("eeprom load test done");
        for (int k = 0; k < 10; k++) begin
            lfsr = next_rand(lfsr);
            rv = (k == 4) ? 32'hffff_ffff : (k == 5) ? 32'h0 : lfsr;
            if (k < 4) rv[7:6] = k[1:0];
            set_cfg(rv);
        end
        $display("register access test done");
        for (int x = 0; x < 20; x++) begin
            lfsr = next_rand(lfsr);
            rv = lfsr;
            rv[23:20] = x[4:1];
            rv[8] = x[0];
            set_cfg(rv); // only supported modes matter to the count
            delim(1'b0, 1'b1);
            if (x == 16) delim(1'b1, 1'b1);
            if (x == 16) delim(1'b0, 1'b0);
        end
        $display("delimiter test done");
        for (int k = 0; k < 8; k++) begin
            lfsr = next_rand(lfsr);
            rom_a[k] = {lfsr[16:3], k[2:0]};
            rom_d[k] = lfsr[31:24];
            io_write(nicfg_pkg::OFS_ROM_ADDR, {15'h0, rom_a[k]});
            io_write(nicfg_pkg::OFS_ROM_DATA, {24'h0, rom_d[k]});
        end
        for (int k = 0; k < 8; k++) begin
            io_write(nicfg_pkg::OFS_ROM_ADDR, {15'h0, rom_a[k]});
            io_read(nicfg_pkg::OFS_ROM_DATA, rv);
            chk({24'h0, rv[7:0]}, {24'h0, rom_d[k]});
        end
        $display("boot rom test done");
        end_sim();
    end
endmodule
